// *** bench/exec_unit_chk.sv ***
// Checker for the execution unit: lengths, flags and branch targets.
// Assumes it is bound to exec_unit and sees only that module's ports.
`timescale 1ns/1ps
module exec_unit_chk (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic START,
  input exec_pkg::instr_s INSTR,
  input wire logic [7:0] DS_RDATA,
  input wire logic WDOG_SEL,
  input exec_pkg::ds_req_s DS_REQ,
  input wire logic [11:0] PC,
  input wire logic FLAG_Z,
  input wire logic FLAG_C,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic ENTER_WAIT,
  input wire logic ENTER_STOP
);
  import exec_pkg::*;
  // ------------------------------------------------------------
  // Helper: last byte read and bit number of the last take
  // ------------------------------------------------------------
  logic [7:0] rd_q, rd_d; // Read byte, kept so carry can be compared
  logic [2:0] bit_q, bit_d; // Bit number of the instruction taken
  // Next values
  always_comb begin
    rd_d = DS_REQ.rd ? DS_RDATA : rd_q;
    bit_d = (START && !BUSY) ? INSTR.opcode[7:5] : bit_q;
  end
  // Registers only
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_q <= 8'h00;
      bit_q <= 3'h0;
    end else begin
      rd_q <= rd_d;
      bit_q <= bit_d;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Steps: an instruction is taken, then its class decides the rest
  sequence s_take; START && !BUSY; endsequence
  sequence s_bt;
    s_take ##0 INSTR.op inside {OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_IF_BIT_SET};
  endsequence
  property p_alu_len;
    s_take ##0 INSTR.op inside {[OP_ADD:OP_SUB], OP_BIT_SET, OP_BIT_CLEAR}
    |-> ##1 !DONE [*3] ##1 DONE;
  endproperty
  a_alu_len: assert property (p_alu_len) else $error("alu length");
  property p_short_len;
    s_take ##0 INSTR.op inside {[OP_BRANCH_IF_CARRY:OP_BRANCH_IF_NONZERO],
      [OP_NOP:OP_WAIT]} |-> ##1 !DONE ##1 DONE;
  endproperty
  a_short_len: assert property (p_short_len) else $error("short len");
  property p_bt_len;
    s_bt |-> ##1 !DONE [*4] ##1 DONE;
  endproperty
  a_bt_len: assert property (p_bt_len) else $error("bit test len");
  property p_bt_carry;
    s_bt |-> ##2 FLAG_C == rd_q[bit_q];
  endproperty
  a_bt_carry: assert property (p_bt_carry) else $error("carry bit");
  property p_bt_zero;
    s_bt |-> ##1 $stable(FLAG_Z) [*5];
  endproperty
  a_bt_zero: assert property (p_bt_zero) else $error("zero moved");
  property p_fwd;
    s_take ##0 (INSTR.op == OP_BRANCH_IF_CARRY && FLAG_C && !INSTR.opcode[4])
    |-> ##2 PC == $past(PC, 2) + $past(INSTR.opcode[3:0], 2) + 12'h1;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward target");
  property p_no_take;
    s_take ##0 (INSTR.op == OP_BRANCH_IF_ZERO && !FLAG_Z)
    |-> ##2 PC == $past(PC, 2) + 12'h1;
  endproperty
  a_no_take: assert property (p_no_take) else $error("branch taken");
  property p_jump;
    s_take ##0 INSTR.op == OP_JUMP
    |-> ##2 PC == {$past(INSTR.opcode[7:4], 2), $past(INSTR.byte2, 2)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target");
  property p_ptr;
    s_take ##0 (INSTR.mode == MODE_IND && INSTR.op <= OP_INC)
    |-> ##1 DS_REQ.rd && DS_REQ.addr == {7'h40, $past(INSTR.opcode[4])};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer select");
  property p_acc_only;
    s_take ##0 INSTR.op inside {[OP_COMPLEMENT_ACCUMULATOR:
      OP_SHIFT_LEFT_ACCUMULATOR]} |-> ##1 !DS_REQ.wr [*4];
  endproperty
  a_acc_only: assert property (p_acc_only) else $error("mem write");
  property p_stop;
    s_take ##0 (INSTR.op == OP_STOP && WDOG_SEL)
    |-> ##2 ENTER_WAIT && !ENTER_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not wait");
endmodule // exec_unit_chk

bind exec_unit exec_unit_chk i_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
  .START(START), .INSTR(INSTR), .DS_RDATA(DS_RDATA), .WDOG_SEL(WDOG_SEL),
  .DS_REQ(DS_REQ), .PC(PC), .FLAG_Z(FLAG_Z), .FLAG_C(FLAG_C), .BUSY(BUSY),
  .DONE(DONE), .ENTER_WAIT(ENTER_WAIT), .ENTER_STOP(ENTER_STOP));

// *** bench/testbench.sv ***
// Self-checking bench for the execution unit.
// Assumes exec_pkg is compiled first; the bench plays fetch and data space.
`timescale 1ns/1ps
module testbench;
  import exec_pkg::*;
  logic core_clk = 0, reset_n = 0, start = 0, wdog_sel = 0;
  instr_s instr = '0;
  logic [11:0] pop_addr = 12'h123; // Return address on the stack
  logic [1:0] saved_flags = 2'h2; // Z set, C clear at interrupt entry
  logic [7:0] mem [256]; // Data space image
  ds_req_s ds_req;
  logic [11:0] pc, push_addr;
  logic [7:0] acc, ds_rdata;
  logic flag_z, flag_c, busy, done, push, pop, ent_wait, ent_stop;
  int miscompares = 0, n_compared = 0, nwr = 0, npush = 0, npop = 0;
  int nw = 0, ns = 0;
  always #4 core_clk = ~core_clk;
  // Unread data is scrambled so a late sample cannot pass by luck
  assign ds_rdata = ds_req.rd ? mem[ds_req.addr] : ~mem[ds_req.addr];
  // Data space writes and pulse counters, mid-cycle so no edge race
  always @(negedge core_clk) begin
    if (ds_req.wr) mem[ds_req.addr] <= ds_req.wdata;
    nwr += ds_req.wr;
    npush += push;
    npop += pop;
    nw += ent_wait;
    ns += ent_stop;
  end
  exec_unit i_dut (.CORE_CLK(core_clk), .RESET_N(reset_n), .START(start),
    .INSTR(instr), .DS_RDATA(ds_rdata), .POP_ADDR(pop_addr),
    .SAVED_FLAGS(saved_flags), .WDOG_SEL(wdog_sel), .DS_REQ(ds_req),
    .PC(pc), .ACC(acc), .FLAG_Z(flag_z), .FLAG_C(flag_c), .BUSY(busy),
    .DONE(done), .STACK_PUSH(push), .PUSH_ADDR(push_addr),
    .STACK_POP(pop), .ENTER_WAIT(ent_wait), .ENTER_STOP(ent_stop));
  task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One instruction: take, wait for done, then compare state {z,c}
  task automatic step(op_e op, mode_e m, logic [7:0] oc, logic [7:0] b2,
    logic [7:0] b3, logic [1:0] ln, int n, logic [11:0] xpc,
    logic [7:0] xa, logic [1:0] xzc);
    int k;
    @(negedge core_clk);
    instr = '{op, m, oc, b2, b3, ln};
    start = 1;
    @(negedge core_clk);
    start = 0;
    k = 1;
    while (done !== 1'b1 && k < 9) begin
      @(negedge core_clk);
      k++;
    end
    check("cycles", 12'(k), 12'(n));
    check("pc", pc, xpc);
    check("acc", {4'h0, acc}, {4'h0, xa});
    check("flags", {10'h0, flag_z, flag_c}, {10'h0, xzc});
    check("busy", {11'h0, busy}, 12'h1);
  endtask
  task automatic t_alu();
    mem[8'h20] = 8'h20;
    mem[8'h80] = 8'h21;
    mem[8'h21] = 8'h01;
    step(OP_ADD, MODE_IMM, 8'h0, 8'hf0, 8'h0, 2, 4, 12'h2, 8'hf0, 2'h0);
    step(OP_ADD, MODE_DIR, 8'h0, 8'h20, 8'h0, 2, 4, 12'h4, 8'h10, 2'h1);
    step(OP_SUB, MODE_IMM, 8'h0, 8'h11, 8'h0, 2, 4, 12'h6, 8'hff, 2'h1);
    step(OP_AND, MODE_IMM, 8'h0, 8'h0f, 8'h0, 2, 4, 12'h8, 8'h0f, 2'h0);
    step(OP_CP, MODE_IMM, 8'h0, 8'h0f, 8'h0, 2, 4, 12'ha, 8'h0f, 2'h2);
    step(OP_ADD, MODE_IND, 8'h0, 8'h0, 8'h0, 1, 4, 12'hb, 8'h10, 2'h0);
  endtask
  task automatic t_mem();
    mem[8'h81] = 8'h40;
    mem[8'h40] = 8'hff;
    mem[8'hff] = 8'h02;
    mem[8'h33] = 8'h5a;
    step(OP_INC, MODE_IND, 8'h10, 8'h0, 8'h0, 1, 4, 12'hc, 8'h10, 2'h2);
    check("inc_mem", {4'h0, mem[8'h40]}, 12'h0);
    step(OP_DEC, MODE_DIR, 8'h0, 8'hff, 8'h0, 2, 4, 12'he, 8'h10, 2'h0);
    check("dec_mem", {4'h0, mem[8'hff]}, 12'h1);
    step(OP_CLR, MODE_DIR, 8'h0, 8'h33, 8'h0, 3, 4, 12'h11, 8'h10, 2'h0);
    check("clr_mem", {4'h0, mem[8'h33]}, 12'h0);
    step(OP_INC, MODE_ACC, 8'h0, 8'h0, 8'h0, 2, 4, 12'h13, 8'h11, 2'h0);
    step(OP_CLR, MODE_ACC, 8'h0, 8'h0, 8'h0, 2, 4, 12'h15, 8'h0, 2'h2);
  endtask
  // Accumulator-only group given a memory mode must still leave memory
  task automatic t_acc();
    int n0;
    n0 = nwr;
    step(OP_COMPLEMENT_ACCUMULATOR, MODE_DIR, 8'h0, 8'h33, 8'h0, 1, 4,
      12'h16, 8'hff, 2'h0);
    step(OP_ROTATE_LEFT_THROUGH_CARRY, MODE_DIR, 8'h0, 8'h33, 8'h0, 1, 4,
      12'h17, 8'hfe, 2'h1);
    step(OP_SHIFT_LEFT_ACCUMULATOR, MODE_DIR, 8'h0, 8'h33, 8'h0, 2, 4,
      12'h19, 8'hfc, 2'h1);
    check("writes", 12'(nwr - n0), 12'h0);
  endtask
  task automatic t_short();
    step(OP_BRANCH_IF_CARRY, MODE_IMM, 8'h0f, 8'h0, 8'h0, 1, 2, 12'h29,
      8'hfc, 2'h1);
    step(OP_BRANCH_IF_NO_CARRY, MODE_IMM, 8'h0f, 8'h0, 8'h0, 1, 2, 12'h2a,
      8'hfc, 2'h1);
    step(OP_BRANCH_IF_ZERO, MODE_IMM, 8'h1f, 8'h0, 8'h0, 1, 2, 12'h2b,
      8'hfc, 2'h1);
    step(OP_BRANCH_IF_NONZERO, MODE_IMM, 8'h1f, 8'h0, 8'h0, 1, 2, 12'h1c,
      8'hfc, 2'h1);
    step(OP_BRANCH_IF_CARRY, MODE_IMM, 8'h00, 8'h0, 8'h0, 1, 2, 12'h1d,
      8'hfc, 2'h1);
  endtask
  // Both displacement ends, taken and not taken, carry copied
  task automatic t_btest();
    mem[8'h30] = 8'h20;
    step(OP_BRANCH_IF_BIT_CLEAR, MODE_DIR, 8'h00, 8'h30, 8'h7f, 3, 5,
      12'h9e, 8'hfc, 2'h0);
    step(OP_BRANCH_IF_BIT_SET, MODE_DIR, 8'ha0, 8'h30, 8'h80, 3, 5,
      12'h20, 8'hfc, 2'h1);
    step(OP_BRANCH_IF_BIT_CLEAR, MODE_DIR, 8'ha0, 8'h30, 8'h7f, 3, 5,
      12'h23, 8'hfc, 2'h1);
  endtask
  task automatic t_bits();
    mem[8'h50] = 8'h00;
    mem[8'h51] = 8'hff;
    step(OP_BIT_SET, MODE_DIR, 8'he0, 8'h50, 8'h0, 2, 4, 12'h25, 8'hfc,
      2'h1);
    check("set_mem", {4'h0, mem[8'h50]}, 12'h80);
    step(OP_BIT_CLEAR, MODE_DIR, 8'h00, 8'h51, 8'h0, 2, 4, 12'h27, 8'hfc,
      2'h1);
    check("clr_bit", {4'h0, mem[8'h51]}, 12'hfe);
  endtask
  task automatic t_jump();
    step(OP_JUMP, MODE_IMM, 8'ha0, 8'h34, 8'h0, 2, 4, 12'ha34, 8'hfc,
      2'h1);
    step(OP_CALL, MODE_IMM, 8'h10, 8'h55, 8'h0, 2, 4, 12'h155, 8'hfc,
      2'h1);
    check("push_addr", push_addr, 12'ha36);
    check("pushes", 12'(npush), 12'h1);
  endtask
  task automatic t_ctrl();
    step(OP_RETURN, MODE_IMM, 8'h0, 8'h0, 8'h0, 1, 2, 12'h123, 8'hfc, 2'h1);
    step(OP_NOP, MODE_IMM, 8'h0, 8'h0, 8'h0, 1, 2, 12'h124, 8'hfc, 2'h1);
    step(OP_WAIT, MODE_IMM, 8'h0, 8'h0, 8'h0, 1, 2, 12'h125, 8'hfc, 2'h1);
    step(OP_STOP, MODE_IMM, 8'h0, 8'h0, 8'h0, 1, 2, 12'h126, 8'hfc, 2'h1);
    wdog_sel = 1;
    step(OP_STOP, MODE_IMM, 8'h0, 8'h0, 8'h0, 1, 2, 12'h127, 8'hfc, 2'h1);
    @(negedge core_clk);
    check("stops", 12'(ns), 12'h1);
    check("waits", 12'(nw), 12'h2);
    step(OP_RETURN_FROM_INTERRUPT, MODE_IMM, 8'h0, 8'h0, 8'h0, 1, 2,
      12'h123, 8'hfc, 2'h2);
    @(negedge core_clk);
    check("pops", 12'(npop), 12'h2);
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run is well under 10 us; this cuts a hang short
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1;
    t_alu();
    t_mem();
    t_acc();
    t_short();
    t_btest();
    t_bits();
    t_jump();
    t_ctrl();
    report_and_stop();
  end
endmodule // testbench

// *** hw/exec_unit.sv ***
// Execution unit: arithmetic/logic, branches, bit ops, jumps, control.
// Assumes the fetch logic supplies a decoded instruction with a one-cycle
// start strobe, a data space answering reads in the same cycle, and an
// external return stack.
//
// How it works
// - Add/and/compare/subtract use accumulator plus memory/immediate
// - Clear/decrement/increment reach all 256 data bytes
// - Complement/rotate/shift act on accumulator only
// - Short branch taken only when its flag condition holds
// - Short branch reach is fifteen back, sixteen forward
// - Bit-test branch uses signed byte, reach -126..+129
// - Bit-test copies tested bit into carry, zero kept
// - Set/clear any bit by 3-bit field, flags kept
// - Jump/call take 12-bit target, flags kept
// - Stop becomes wait when watchdog is selected
// - Short branch opcode holds direction bit and span
// - Opcode bit 4 picks pointer at 80h or 81h
`timescale 1ns/1ps
module exec_unit #(
  parameter logic [11:0] RESET_PC = 12'h000 // Start address after reset
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic START,
  input exec_pkg::instr_s INSTR,
  input wire logic [7:0] DS_RDATA,
  input wire logic [11:0] POP_ADDR,
  input wire logic [1:0] SAVED_FLAGS,
  input wire logic WDOG_SEL,
  output exec_pkg::ds_req_s DS_REQ,
  output logic [11:0] PC,
  output logic [7:0] ACC,
  output logic FLAG_Z,
  output logic FLAG_C,
  output logic BUSY,
  output logic DONE,
  output logic STACK_PUSH,
  output logic [11:0] PUSH_ADDR,
  output logic STACK_POP,
  output logic ENTER_WAIT,
  output logic ENTER_STOP
);
  import exec_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, // Waiting for a start strobe
    ST_PTR = 2'h1,  // Pointer register being read
    ST_EXEC = 2'h2, // Operand on the bus, result computed
    ST_HOLD = 2'h3  // Padding out to the instruction length
  } state_e;

  state_e state_q, state_d;
  instr_s ir_q, ir_d;          // Instruction being executed
  logic [2:0] cnt_q, cnt_d;    // Cycles since the instruction was taken
  logic [2:0] total_q, total_d; // Cycle count of this instruction
  ds_req_s ds_q, ds_d;
  logic [11:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d;
  logic z_q, z_d, c_q, c_d;
  logic busy_q, busy_d, done_q, done_d;
  logic push_q, push_d, pop_q, pop_d;
  logic [11:0] push_addr_q, push_addr_d;
  logic wait_q, wait_d, stop_q, stop_d;

  // ----------------------------------------------------------------
  // Combinational helpers for the instruction in EXEC
  // ----------------------------------------------------------------
  logic [7:0] opnd;       // Second ALU operand
  logic [8:0] sum9, diff9; // Carry and borrow in bit 8
  logic [2:0] bitn;       // Selected bit number
  logic tbit;             // Tested bit of the data byte
  logic [11:0] pc_next;   // Address of the following instruction
  logic [11:0] span;      // Short branch span, zero extended
  logic [7:0] r;          // Clear/inc/dec result
  logic take;             // Short branch condition met

  always_comb begin
    // Operand source by addressing mode
    unique case (ir_q.mode)
      MODE_IMM: opnd = ir_q.byte2;
      MODE_ACC: opnd = acc_q;
      default: opnd = DS_RDATA; // Direct and indirect read the bus
    endcase
    sum9 = {1'b0, acc_q} + {1'b0, opnd};
    diff9 = {1'b0, acc_q} - {1'b0, opnd};
    bitn = ir_q.opcode[OPC_BIT_LSB +: 3];
    tbit = DS_RDATA[bitn];
    pc_next = pc_q + 12'(ir_q.len);
    span = 12'(ir_q.opcode[OPC_SPAN_LSB +: 4]);
  end

  // Cycle count per operation class
  function automatic logic [2:0] cycles_of(input op_e op);
    unique case (op)
      OP_BRANCH_IF_CARRY, OP_BRANCH_IF_NO_CARRY, OP_BRANCH_IF_ZERO,
      OP_BRANCH_IF_NONZERO, OP_NOP, OP_RETURN, OP_RETURN_FROM_INTERRUPT,
      OP_STOP, OP_WAIT: cycles_of = CYC_SHORT;
      OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_IF_BIT_SET:
        cycles_of = CYC_BTEST;
      OP_JUMP, OP_CALL: cycles_of = CYC_JUMP;
      default: cycles_of = CYC_ALU;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ir_d = ir_q;
    cnt_d = cnt_q + 3'h1;
    total_d = total_q;
    ds_d = '0; // Strobes last one cycle unless set below
    ds_d.addr = ds_q.addr;
    pc_d = pc_q;
    acc_d = acc_q;
    z_d = z_q;
    c_d = c_q;
    push_d = 1'b0;
    pop_d = 1'b0;
    push_addr_d = push_addr_q;
    wait_d = 1'b0;
    stop_d = 1'b0;
    r = 8'h00;
    take = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        cnt_d = 3'h0;
        if (START) begin
          ir_d = INSTR;
          total_d = cycles_of(INSTR.op);
          if (INSTR.mode == MODE_IND) begin
            // Pointer chosen by one opcode bit
            ds_d.addr = INSTR.opcode[OPC_PTR_BIT] ? PTR_Y_ADDR
                                                  : PTR_X_ADDR;
            ds_d.rd = 1'b1;
            state_d = ST_PTR;
          end else begin
            // Direct operands and bit-op bytes sit at byte2
            ds_d.addr = INSTR.byte2;
            ds_d.rd = (INSTR.mode == MODE_DIR);
            state_d = ST_EXEC;
          end
        end
      end
      ST_PTR: begin
        // Pointer value becomes the operand address
        ds_d.addr = DS_RDATA;
        ds_d.rd = 1'b1;
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        state_d = ST_HOLD;
        pc_d = pc_next;
        unique case (ir_q.op)
          OP_ADD: begin
            acc_d = sum9[7:0];
            c_d = sum9[8];
            z_d = (sum9[7:0] == 8'h00);
          end
          OP_AND: begin
            acc_d = acc_q & opnd;
            c_d = 1'b0;
            z_d = ((acc_q & opnd) == 8'h00);
          end
          OP_SUB, OP_CP: begin
            // Compare keeps the accumulator, flags only
            if (ir_q.op == OP_SUB) begin
              acc_d = diff9[7:0];
            end
            c_d = diff9[8];
            z_d = (diff9[7:0] == 8'h00);
          end
          OP_CLR, OP_DEC, OP_INC: begin
            r = (ir_q.op == OP_CLR) ? 8'h00 :
                (ir_q.op == OP_INC) ? opnd + 8'h01 : opnd - 8'h01;
            if (ir_q.mode == MODE_ACC) begin
              acc_d = r;
              z_d = (r == 8'h00);
              if (ir_q.op == OP_CLR) begin
                c_d = 1'b0;
              end
            end else begin
              // Memory clear leaves flags; inc/dec touch zero only
              ds_d.wr = 1'b1;
              ds_d.wdata = r;
              if (ir_q.op != OP_CLR) begin
                z_d = (r == 8'h00);
              end
            end
          end
          OP_COMPLEMENT_ACCUMULATOR: begin
            acc_d = ~acc_q;
            c_d = acc_q[7];
            z_d = (acc_q == 8'hff);
          end
          OP_ROTATE_LEFT_THROUGH_CARRY: begin
            acc_d = {acc_q[6:0], c_q};
            c_d = acc_q[7];
            z_d = ({acc_q[6:0], c_q} == 8'h00);
          end
          OP_SHIFT_LEFT_ACCUMULATOR: begin
            acc_d = {acc_q[6:0], 1'b0};
            c_d = acc_q[7];
            z_d = (acc_q[6:0] == 7'h00);
          end
          OP_BRANCH_IF_CARRY, OP_BRANCH_IF_NO_CARRY,
          OP_BRANCH_IF_ZERO, OP_BRANCH_IF_NONZERO: begin
            take = (ir_q.op == OP_BRANCH_IF_CARRY) ? c_q :
                   (ir_q.op == OP_BRANCH_IF_NO_CARRY) ? !c_q :
                   (ir_q.op == OP_BRANCH_IF_ZERO) ? z_q : !z_q;
            if (take) begin
              // Backward by span, forward by span plus one
              pc_d = ir_q.opcode[OPC_DIR_BIT] ? pc_q - span
                                              : pc_q + span + 12'h001;
            end
          end
          OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_IF_BIT_SET: begin
            c_d = tbit;
            if (tbit == (ir_q.op == OP_BRANCH_IF_BIT_SET)) begin
              // Base is two past the opcode: -126..+129
              pc_d = pc_q + 12'h002
                   + {{4{ir_q.byte3[7]}}, ir_q.byte3};
            end
          end
          OP_BIT_SET, OP_BIT_CLEAR: begin
            ds_d.wr = 1'b1;
            ds_d.wdata = DS_RDATA;
            ds_d.wdata[bitn] = (ir_q.op == OP_BIT_SET);
          end
          OP_JUMP, OP_CALL: begin
            pc_d = {ir_q.opcode[OPC_HI_LSB +: 4], ir_q.byte2};
            if (ir_q.op == OP_CALL) begin
              push_d = 1'b1;
              push_addr_d = pc_next;
            end
          end
          OP_RETURN, OP_RETURN_FROM_INTERRUPT: begin
            pc_d = POP_ADDR;
            pop_d = 1'b1;
            if (ir_q.op == OP_RETURN_FROM_INTERRUPT) begin
              {z_d, c_d} = SAVED_FLAGS;
            end
          end
          OP_STOP: begin
            // Watchdog forbids stopping the clock: fall back to wait
            wait_d = WDOG_SEL;
            stop_d = !WDOG_SEL;
          end
          OP_WAIT: wait_d = 1'b1;
          default: ; // No-operation changes nothing but the address
        endcase
      end
      ST_HOLD: ; // Padding only
    endcase
    // Leave after the last counted cycle
    if (state_q != ST_IDLE && cnt_q == total_q - 3'h1) begin
      state_d = ST_IDLE;
    end
    busy_d = (state_d != ST_IDLE);
    done_d = busy_d && (cnt_d == total_d - 3'h1);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      ir_q <= '0;
      cnt_q <= 3'h0;
      total_q <= 3'h0;
      ds_q <= '0;
      pc_q <= RESET_PC;
      acc_q <= 8'h00;
      z_q <= 1'b0;
      c_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      push_addr_q <= 12'h000;
      wait_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ir_q <= ir_d;
      cnt_q <= cnt_d;
      total_q <= total_d;
      ds_q <= ds_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      z_q <= z_d;
      c_q <= c_d;
      busy_q <= busy_d;
      done_q <= done_d;
      push_q <= push_d;
      pop_q <= pop_d;
      push_addr_q <= push_addr_d;
      wait_q <= wait_d;
      stop_q <= stop_d;
    end
  end

  // Every output straight from a flip-flop
  assign DS_REQ = ds_q;
  assign PC = pc_q;
  assign ACC = acc_q;
  assign FLAG_Z = z_q;
  assign FLAG_C = c_q;
  assign BUSY = busy_q;
  assign DONE = done_q;
  assign STACK_PUSH = push_q;
  assign PUSH_ADDR = push_addr_q;
  assign STACK_POP = pop_q;
  assign ENTER_WAIT = wait_q;
  assign ENTER_STOP = stop_q;

endmodule // exec_unit

// *** shared/exec_pkg.sv ***
// Shared types and constants for the core execution unit.
// Assumes one core clock and a data space with same-cycle read data.
package exec_pkg;

  // ----------------------------------------------------------------
  // Widths and fixed data-space addresses
  // ----------------------------------------------------------------
  localparam int PC_W = 12;               // Program space address width
  localparam logic [7:0] PTR_X_ADDR = 8'h80; // First pointer register
  localparam logic [7:0] PTR_Y_ADDR = 8'h81; // Second pointer register

  // ----------------------------------------------------------------
  // Opcode field positions
  // ----------------------------------------------------------------
  localparam int OPC_PTR_BIT = 4;  // Pointer select for indirect mode
  localparam int OPC_DIR_BIT = 4;  // Short branch direction, 1 = back
  localparam int OPC_SPAN_LSB = 0; // Short branch span, 4 bits
  localparam int OPC_BIT_LSB = 5;  // Bit number, 3 bits
  localparam int OPC_HI_LSB = 4;   // Upper target nibble of jump/call

  // ----------------------------------------------------------------
  // Execution lengths in machine cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_ALU = 3'h4;   // Arithmetic, logic, set/clear
  localparam logic [2:0] CYC_SHORT = 3'h2; // Short branch and control
  localparam logic [2:0] CYC_BTEST = 3'h5; // Bit-test branch
  localparam logic [2:0] CYC_JUMP = 3'h4;  // Jump and call

  // ----------------------------------------------------------------
  // Operations and addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_AND = 5'h01, OP_CP = 5'h02, OP_SUB = 5'h03,
    OP_CLR = 5'h04, OP_DEC = 5'h05, OP_INC = 5'h06,
    OP_COMPLEMENT_ACCUMULATOR = 5'h07,
    OP_ROTATE_LEFT_THROUGH_CARRY = 5'h08,
    OP_SHIFT_LEFT_ACCUMULATOR = 5'h09,
    OP_BRANCH_IF_CARRY = 5'h0a, OP_BRANCH_IF_NO_CARRY = 5'h0b,
    OP_BRANCH_IF_ZERO = 5'h0c, OP_BRANCH_IF_NONZERO = 5'h0d,
    OP_BRANCH_IF_BIT_CLEAR = 5'h0e, OP_BRANCH_IF_BIT_SET = 5'h0f,
    OP_BIT_SET = 5'h10, OP_BIT_CLEAR = 5'h11,
    OP_JUMP = 5'h12, OP_CALL = 5'h13,
    OP_NOP = 5'h14, OP_RETURN = 5'h15, OP_RETURN_FROM_INTERRUPT = 5'h16,
    OP_STOP = 5'h17, OP_WAIT = 5'h18
  } op_e;

  typedef enum logic [1:0] {
    MODE_IMM = 2'h0, // Operand is the byte after the opcode
    MODE_DIR = 2'h1, // Byte after the opcode is a data address
    MODE_IND = 2'h2, // Address held in a pointer register
    MODE_ACC = 2'h3  // Operand is the accumulator
  } mode_e;

  // One decoded instruction as handed over by the fetch logic
  typedef struct packed {
    op_e op;
    mode_e mode;
    logic [7:0] opcode; // Raw first byte
    logic [7:0] byte2;  // Immediate, data address or target low byte
    logic [7:0] byte3;  // Bit-test displacement
    logic [1:0] len;    // Instruction length in bytes
  } instr_s;

  // Data-space access, one per cycle
  typedef struct packed {
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } ds_req_s;

endpackage
